/* File: core/ppc_pkg.sv */
package ppc_pkg;
    // register byte addresses, 8-pin analog-capable port
    localparam logic [7:0] ADDR_A_LATCH = 8'h00;
    localparam logic [7:0] ADDR_A_LEVEL = 8'h01;
    localparam logic [7:0] ADDR_A_DIR = 8'h02;
    localparam logic [7:0] ADDR_A_PULL_EN = 8'h03;
    localparam logic [7:0] ADDR_A_POLARITY = 8'h04;
    localparam logic [7:0] ADDR_A_IRQ_EN = 8'h05;
    localparam logic [7:0] ADDR_A_DIG_GATE = 8'h06;
    localparam logic [7:0] ADDR_A_RED_DRIVE = 8'h07;
    localparam logic [7:0] ADDR_A_OPEN_DRAIN = 8'h08;
    // register byte addresses, 2-pin high-voltage port
    localparam logic [7:0] ADDR_L_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_L_POLARITY = 8'h11;
    localparam logic [7:0] ADDR_L_IRQ_EN = 8'h12;
    localparam logic [7:0] ADDR_L_DIG_GATE = 8'h13;
    // first address above the map
    localparam logic [7:0] ADDR_TOP = 8'h14;

    // port widths
    localparam int A_PINS = 8;
    localparam int L_PINS = 2;

    // reset values
    localparam logic [7:0] RST_A_REG = 8'h00;
    localparam logic [1:0] RST_L_REG = 2'h0;
    localparam logic [7:0] RST_OE_N = 8'hFF;
    localparam logic [7:0] RST_RDATA = 8'h00;
endpackage : ppc_pkg

/* File: core/ppc_sync.sv */
module ppc_sync import ppc_pkg::*; #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // two-flop synchroniser, first stage read only by second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : ppc_sync

/* File: core/ppc_pin_cell.sv */
module ppc_pin_cell import ppc_pkg::*; (
    // general-purpose configuration
    input wire logic gp_data,
    input wire logic gp_dir,
    input wire logic pull_en,
    input wire logic pull_pol,
    input wire logic open_drain,
    // peripheral requests
    input wire logic dac_en,
    input wire logic iic_en,
    input wire logic iic_out,
    input wire logic spi_en,
    input wire logic spi_oe,
    input wire logic spi_out,
    input wire logic sent_en,
    input wire logic sent_out,
    input wire logic ocmp_en,
    input wire logic ocmp_out,
    input wire logic in_only,
    // resolved pad controls
    output logic drive_en,
    output logic drive_val,
    output logic pull_up,
    output logic pull_dn
);
    logic want;
    logic val;
    logic od;
    logic kill_pull;

    always_comb begin
        want = 1'b0;
        val = 1'b0;
        od = open_drain;
        kill_pull = 1'b0;
        // RULE_10 fixed priority chain
        if (dac_en) begin
            // RULE_14 driver and pulls off
            kill_pull = 1'b1;
        end else if (iic_en) begin
            // RULE_18 forced open drain
            want = 1'b1;
            val = iic_out;
            od = 1'b1;
        end else if (spi_en) begin
            // RULE_12 serial takes control
            want = spi_oe;
            val = spi_out;
        end else if (sent_en) begin
            // RULE_13 forced output
            want = 1'b1;
            val = sent_out;
        end else if (ocmp_en) begin
            // RULE_11 forced output, pulls off
            want = 1'b1;
            val = ocmp_out;
            kill_pull = 1'b1;
        end else if (in_only) begin
            // RULE_17 forced input, pulls untouched
            want = 1'b0;
        end else begin
            // RULE_01 software direction and data
            want = gp_dir;
            val = gp_data;
        end
        // open drain only sinks
        drive_en = want & ~(od & val);
        drive_val = val & ~od;
        // RULE_04 pull-up off under push-pull drive
        pull_up = pull_en & ~pull_pol & ~kill_pull & ~(want & ~od);
        // pull-down off on any output, push-pull or open drain
        pull_dn = pull_en & pull_pol & ~kill_pull & ~want;
    end
endmodule : ppc_pin_cell

/* File: core/ppc_port_pin_io_control.sv */
// Overview of operation
// RULE_01: all non-debug pins usable as software I/O
// RULE_02: pins also carry shared peripheral signals
// RULE_03: configuration writes accepted at any time
// RULE_04: pull-up inactive under push-pull output
// RULE_05: unimplemented bits read as zero
// RULE_06: implemented bit widths differ per port
// RULE_07: input register returns real pin level
// RULE_08: data read returns pin level when input
// RULE_09: enabled peripheral overrides software direction
// RULE_10: highest ranked enabled peripheral wins pin
// RULE_11: compare output forces output, pulls off
// RULE_12: serial owns pins, pulls off on outputs (pull-up stays on open-drain serial outputs)
// RULE_13: edge-sensor transmit forces output, pulls limited
// RULE_14: converter output kills driver and pulls
// RULE_15: software sets digital gate before digital use
// RULE_16: software selects routing before override applies
// RULE_17: peripheral inputs force input, pulls unchanged
// RULE_18: two-wire serial forces open drain, no pulldown
//
// The implementer's own choices: the address map and the strobed register port.
module ppc_port_pin_io_control import ppc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // port A pads
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    output logic [7:0] pull_up_en,
    output logic [7:0] pull_dn_en,
    output logic [7:0] in_buf_en,
    output logic [7:0] reduced_drive,
    // port A peripheral requests, already routed
    input wire logic [7:0] dac_en,
    input wire logic [7:0] iic_en,
    input wire logic [7:0] iic_out,
    input wire logic [7:0] spi_en,
    input wire logic [7:0] spi_oe,
    input wire logic [7:0] spi_out,
    input wire logic [7:0] sent_en,
    input wire logic [7:0] sent_out,
    input wire logic [7:0] ocmp_en,
    input wire logic [7:0] ocmp_out,
    input wire logic [7:0] in_only,
    // port A levels and settings to peripherals and filters
    output logic [7:0] pin_level,
    output logic [7:0] a_pull_polarity,
    output logic [7:0] a_irq_enable,
    // port L pads and settings
    input wire logic [1:0] l_pad_in,
    output logic [1:0] l_in_buf_en,
    output logic [1:0] l_pin_level,
    output logic [1:0] l_pull_polarity,
    output logic [1:0] l_irq_enable
);
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] pull_en_q;
    logic [7:0] pol_q;
    logic [7:0] irq_en_q;
    logic [7:0] gate_q;
    logic [7:0] red_q;
    logic [7:0] od_q;
    logic [1:0] l_pol_q;
    logic [1:0] l_irq_q;
    logic [1:0] l_gate_q;
    logic [7:0] rdata_d;
    logic [7:0] drive_en_d;
    logic [7:0] drive_val_d;
    logic [7:0] pull_up_d;
    logic [7:0] pull_dn_d;

    // RULE_07 pads synchronised before any read
    ppc_sync #(
        .WIDTH(A_PINS)
    ) u_sync_a (
        .clk(clk),
        .reset(reset),
        .async_in(pad_in),
        .sync_out(pin_level)
    );

    ppc_sync #(
        .WIDTH(L_PINS)
    ) u_sync_l (
        .clk(clk),
        .reset(reset),
        .async_in(l_pad_in),
        .sync_out(l_pin_level)
    );

    // RULE_03 port A writes never gated by pin use
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_q <= RST_A_REG;
            dir_q <= RST_A_REG;
            pull_en_q <= RST_A_REG;
            pol_q <= RST_A_REG;
        end else if (wr) begin
            case (addr)
                ADDR_A_LATCH: latch_q <= wdata;
                ADDR_A_DIR: dir_q <= wdata;
                ADDR_A_PULL_EN: pull_en_q <= wdata;
                ADDR_A_POLARITY: pol_q <= wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_en_q <= RST_A_REG;
            gate_q <= RST_A_REG;
            red_q <= RST_A_REG;
            od_q <= RST_A_REG;
        end else if (wr) begin
            case (addr)
                ADDR_A_IRQ_EN: irq_en_q <= wdata;
                ADDR_A_DIG_GATE: gate_q <= wdata;
                ADDR_A_RED_DRIVE: red_q <= wdata;
                ADDR_A_OPEN_DRAIN: od_q <= wdata;
                default: ;
            endcase
        end
    end

    // RULE_06 port L keeps two bits, level is read only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            l_pol_q <= RST_L_REG;
            l_irq_q <= RST_L_REG;
            l_gate_q <= RST_L_REG;
        end else if (wr) begin
            case (addr)
                ADDR_L_POLARITY: l_pol_q <= wdata[1:0];
                ADDR_L_IRQ_EN: l_irq_q <= wdata[1:0];
                ADDR_L_DIG_GATE: l_gate_q <= wdata[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        case (addr)
            // RULE_08 input pins show level, outputs the latch
            ADDR_A_LATCH: rdata_d = (dir_q & latch_q) | (~dir_q & pin_level);
            // RULE_07 actual level regardless of owner
            ADDR_A_LEVEL: rdata_d = pin_level;
            ADDR_A_DIR: rdata_d = dir_q;
            ADDR_A_PULL_EN: rdata_d = pull_en_q;
            ADDR_A_POLARITY: rdata_d = pol_q;
            ADDR_A_IRQ_EN: rdata_d = irq_en_q;
            ADDR_A_DIG_GATE: rdata_d = gate_q;
            ADDR_A_RED_DRIVE: rdata_d = red_q;
            ADDR_A_OPEN_DRAIN: rdata_d = od_q;
            // RULE_05 upper bits of port L read zero
            ADDR_L_LEVEL: rdata_d = {6'h00, l_pin_level};
            ADDR_L_POLARITY: rdata_d = {6'h00, l_pol_q};
            ADDR_L_IRQ_EN: rdata_d = {6'h00, l_irq_q};
            ADDR_L_DIG_GATE: rdata_d = {6'h00, l_gate_q};
            default: rdata_d = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= RST_RDATA;
        end else if (rd) begin
            rdata <= rdata_d;
        end else begin
            rdata <= RST_RDATA;
        end
    end

    // RULE_02 per-pin sharing between software and peripherals
    // RULE_09 peripheral overrides resolved per pin
    for (genvar i = 0; i < A_PINS; i++) begin : g_pin
        ppc_pin_cell u_cell (
            .gp_data(latch_q[i]),
            .gp_dir(dir_q[i]),
            .pull_en(pull_en_q[i]),
            .pull_pol(pol_q[i]),
            .open_drain(od_q[i]),
            .dac_en(dac_en[i]),
            .iic_en(iic_en[i]),
            .iic_out(iic_out[i]),
            .spi_en(spi_en[i]),
            .spi_oe(spi_oe[i]),
            .spi_out(spi_out[i]),
            .sent_en(sent_en[i]),
            .sent_out(sent_out[i]),
            .ocmp_en(ocmp_en[i]),
            .ocmp_out(ocmp_out[i]),
            .in_only(in_only[i]),
            .drive_en(drive_en_d[i]),
            .drive_val(drive_val_d[i]),
            .pull_up(pull_up_d[i]),
            .pull_dn(pull_dn_d[i])
        );
    end

    // pad controls registered, released at reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pad_out <= RST_A_REG;
            pad_oe_n <= RST_OE_N;
            pull_up_en <= RST_A_REG;
            pull_dn_en <= RST_A_REG;
        end else begin
            pad_out <= drive_val_d;
            pad_oe_n <= ~drive_en_d;
            pull_up_en <= pull_up_d;
            pull_dn_en <= pull_dn_d;
        end
    end

    // RULE_15 input buffers follow the digital gate bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_buf_en <= RST_A_REG;
            reduced_drive <= RST_A_REG;
            a_pull_polarity <= RST_A_REG;
            a_irq_enable <= RST_A_REG;
            l_in_buf_en <= RST_L_REG;
            l_pull_polarity <= RST_L_REG;
            l_irq_enable <= RST_L_REG;
        end else begin
            in_buf_en <= gate_q;
            reduced_drive <= red_q;
            a_pull_polarity <= pol_q;
            a_irq_enable <= irq_en_q;
            l_in_buf_en <= l_gate_q;
            l_pull_polarity <= l_pol_q;
            l_irq_enable <= l_irq_q;
        end
    end

    // RULE_04 push-pull high never with a pull
    AST_PUSHPULL_NO_PULL: assert property (@(posedge clk) disable iff (reset) // RULE_04
        (~pad_oe_n & pad_out & (pull_up_en | pull_dn_en)) == 8'h00)
        else $error("pull active on push-pull driven pin");

    // RULE_14 converter pin undriven and unpulled
    AST_DAC_KILLS_PIN: assert property (@(posedge clk) disable iff (reset) // RULE_14
        (dac_en != 8'h00) |=>
        (($past(dac_en) & (~pad_oe_n | pull_up_en | pull_dn_en)) == 8'h00))
        else $error("converter pin still driven or pulled");

    // RULE_11 compare channel on pin 0 has no pulls
    AST_OCMP_NO_PULL: assert property (@(posedge clk) disable iff (reset) // RULE_11
        (ocmp_en[0] && !dac_en[0] && !iic_en[0] && !spi_en[0] && !sent_en[0])
        |=> !pull_up_en[0] && !pull_dn_en[0] && (pad_oe_n[0] == ($past(od_q[0])
        && $past(ocmp_out[0]))))
        else $error("compare pin pull or drive wrong");

    // RULE_18 two-wire pin sinks only, no pulldown
    AST_IIC_OPEN_DRAIN: assert property (@(posedge clk) disable iff (reset) // RULE_18
        (iic_en[0] && !dac_en[0]) |=> !pad_out[0] && !pull_dn_en[0]
        && (pad_oe_n[0] == $past(iic_out[0])))
        else $error("two-wire pin not open drain");

    // RULE_01 plain software output follows latch
    AST_GPIO_OUTPUT: assert property (@(posedge clk) disable iff (reset) // RULE_01
        (dir_q[0] && !od_q[0] && !dac_en[0] && !iic_en[0] && !spi_en[0]
        && !sent_en[0] && !ocmp_en[0] && !in_only[0])
        |=> !pad_oe_n[0] && (pad_out[0] == $past(latch_q[0])))
        else $error("software output not driven");

    // RULE_17 forced input ignores direction
    AST_FORCED_INPUT: assert property (@(posedge clk) disable iff (reset) // RULE_17
        (in_only[0] && !dac_en[0] && !iic_en[0] && !spi_en[0] && !sent_en[0]
        && !ocmp_en[0]) |=> pad_oe_n[0]
        && (pull_up_en[0] == ($past(pull_en_q[0]) && !$past(pol_q[0]))))
        else $error("forced input pin misbehaves");

    // RULE_07 input register returns synchronised level
    AST_LEVEL_READ: assert property (@(posedge clk) disable iff (reset) // RULE_07
        (rd && addr == ADDR_A_LEVEL) |=> rdata == $past(pin_level))
        else $error("level read mismatch");

    // RULE_08 data read mixes latch and level by direction
    AST_DATA_READ: assert property (@(posedge clk) disable iff (reset) // RULE_08
        (rd && addr == ADDR_A_LATCH) |=> rdata == (($past(dir_q) & $past(latch_q))
        | (~$past(dir_q) & $past(pin_level))))
        else $error("data read mismatch");

    // RULE_05 addresses above the map read zero
    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (reset) // RULE_05
        (rd && addr >= ADDR_TOP) |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // RULE_06 port L upper bits zero
    AST_L_NARROW: assert property (@(posedge clk) disable iff (reset) // RULE_06
        (rd && addr >= ADDR_L_LEVEL && addr < ADDR_TOP) |=> rdata[7:2] == 6'h00)
        else $error("port L upper bits set");

    // RULE_03 direction write lands even under override
    AST_WRITE_ANYTIME: assert property (@(posedge clk) disable iff (reset) // RULE_03
        (wr && addr == ADDR_A_DIR) ##1 !(wr && addr == ADDR_A_DIR)
        ##1 (rd && addr == ADDR_A_DIR) |=> rdata == $past(wdata, 3))
        else $error("direction write lost");

    // RULE_12 serial output pin has no pulldown, no pullup unless open drain
    AST_SPI_OUTPUT: assert property (@(posedge clk) disable iff (reset) // RULE_12
        (spi_en[0] && spi_oe[0] && !dac_en[0] && !iic_en[0])
        |=> !pull_dn_en[0] && (!pull_up_en[0] || $past(od_q[0])))
        else $error("serial output pin pulled");

    // RULE_13 sensor transmit pin is output, pulls limited
    AST_SENT_OUTPUT: assert property (@(posedge clk) disable iff (reset) // RULE_13
        (sent_en[0] && !dac_en[0] && !iic_en[0] && !spi_en[0])
        |=> !pull_dn_en[0] && (pad_out[0] == ($past(sent_out[0]) && !$past(od_q[0]))))
        else $error("sensor transmit pin wrong");

    // RULE_10 serial outranks sensor transmit
    AST_SPI_OVER_SENT: assert property (@(posedge clk) disable iff (reset) // RULE_10
        (spi_en[2] && sent_en[2] && !dac_en[2] && !iic_en[2] && !od_q[2])
        |=> (pad_oe_n[2] == !$past(spi_oe[2])) && (pad_out[2] == $past(spi_out[2])))
        else $error("sensor transmit beat serial on pin");

    // RULE_12 pulldown never on a driven pin
    AST_DRIVEN_NO_PULLDOWN: assert property (@(posedge clk) disable iff (reset) // RULE_12
        (~pad_oe_n & pull_dn_en) == 8'h00)
        else $error("pulldown active on driven pin");

    // RULE_07 port L level read back
    AST_L_LEVEL_READ: assert property (@(posedge clk) disable iff (reset) // RULE_07
        (rd && addr == ADDR_L_LEVEL) |=> rdata == {6'h00, $past(l_pin_level)})
        else $error("port L level read mismatch");

    // RULE_05 hole between ports reads zero
    AST_MIDMAP_ZERO: assert property (@(posedge clk) disable iff (reset) // RULE_05
        (rd && addr > ADDR_A_OPEN_DRAIN && addr < ADDR_L_LEVEL) |=> rdata == 8'h00)
        else $error("unmapped mid-map read not zero");

    // RULE_15 buffers follow gate bits
    AST_GATE_TO_BUFFER: assert property (@(posedge clk) disable iff (reset) // RULE_15
        (in_buf_en == $past(gate_q)) && (l_in_buf_en == $past(l_gate_q)))
        else $error("input buffer enable not following gate");
endmodule : ppc_port_pin_io_control

/* File: verification/ppc_pad_model.sv */
module ppc_pad_model (
    // clock for the floating-line pattern
    input wire logic clk,
    // pad controls from the port
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_dn_en,
    // outside driver
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // resolved pad levels
    output logic [7:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_q = 8'h00;
    // undriven lines flip every cycle so no stale level passes
    always @(posedge clk) begin
        last_q <= pad_in;
    end
    // port driver wins, then outside driver, then pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pull_up_en[i]) pad_in[i] = 1'b1;
            else if (pull_dn_en[i]) pad_in[i] = 1'b0;
            else pad_in[i] = ~last_q[i];
        end
    end
endmodule : ppc_pad_model

/* File: verification/ppc_port_pin_io_control_bench.sv */
module ppc_port_pin_io_control_bench import ppc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        int sel;
        logic [7:0] exp;
        logic [7:0] mask;
    } ppc_note_s;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, smp = 1'b0;
    logic [7:0] rdata, pad_in, pad_out, pad_oe_n, pull_up_en, pull_dn_en, in_buf_en;
    logic [7:0] reduced_drive, pin_level, a_pull_polarity, a_irq_enable;
    logic [7:0] dac_en = 8'h00, iic_en = 8'h00, iic_out = 8'h00, spi_en = 8'h00;
    logic [7:0] spi_oe = 8'h00, spi_out = 8'h00, sent_en = 8'h00, sent_out = 8'h00;
    logic [7:0] ocmp_en = 8'h00, ocmp_out = 8'h00, in_only = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00, r, seen;
    logic [1:0] l_pad_in = 2'h0, l_in_buf_en, l_pin_level, l_pull_polarity, l_irq_enable;
    logic [7:0] regv [256];
    logic [7:0] alist [15] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11,
        8'h12, 8'h13, 8'h09, 8'h0F, 8'h14, 8'hFF, 8'h10};
    string names [11] = '{"rdata", "pad_oe_n", "pad_out", "pull_up_en", "pull_dn_en",
        "pin_level", "in_buf_en", "reduced_drive", "a_pull_polarity", "a_irq_enable", "port_l"};
    ppc_note_s q [$];
    ppc_note_s n;
    int err_count = 0;
    int checked = 0;

    ppc_port_pin_io_control ppc_port_pin_io_control_i (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en),
        .in_buf_en(in_buf_en), .reduced_drive(reduced_drive), .dac_en(dac_en),
        .iic_en(iic_en), .iic_out(iic_out), .spi_en(spi_en), .spi_oe(spi_oe),
        .spi_out(spi_out), .sent_en(sent_en), .sent_out(sent_out), .ocmp_en(ocmp_en),
        .ocmp_out(ocmp_out), .in_only(in_only), .pin_level(pin_level),
        .a_pull_polarity(a_pull_polarity), .a_irq_enable(a_irq_enable), .l_pad_in(l_pad_in),
        .l_in_buf_en(l_in_buf_en), .l_pin_level(l_pin_level),
        .l_pull_polarity(l_pull_polarity), .l_irq_enable(l_irq_enable));
    ppc_pad_model ppc_pad_model_i (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [7:0] pick(input int s);
        case (s)
            0: return rdata;
            1: return pad_oe_n;
            2: return pad_out;
            3: return pull_up_en;
            4: return pull_dn_en;
            5: return pin_level;
            6: return in_buf_en;
            7: return reduced_drive;
            8: return a_pull_polarity;
            9: return a_irq_enable;
            default: return {l_in_buf_en, l_pin_level, l_pull_polarity, l_irq_enable};
        endcase
    endfunction : pick

    function automatic logic [7:0] msk(input logic [7:0] a);
        if (a >= ADDR_A_DIR && a <= ADDR_A_OPEN_DRAIN) return 8'hFF;
        if (a >= ADDR_L_POLARITY && a <= ADDR_L_DIG_GATE) return 8'h03;
        return 8'h00;
    endfunction : msk

    function automatic logic [7:0] chk(input logic [7:0] a);
        return (a == ADDR_L_LEVEL) ? 8'hFC : 8'hFF;
    endfunction : chk

    // result watcher: oldest note against what appears
    always @(posedge clk) begin
        rd_seen <= rd;
        if (rd_seen || smp) begin
            n = q.pop_front();
            seen = pick(n.sel);
            checked++;
            if ((seen & n.mask) !== (n.exp & n.mask)) begin
                err_count++;
                $display("mismatch %s expected %h seen %h", names[n.sel], n.exp & n.mask,
                    seen & n.mask);
            end
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        q.push_back('{0, e, m});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd_reg

    task automatic note_out(input int s, input logic [7:0] e, input logic [7:0] m);
        q.push_back('{s, e, m});
        smp <= 1'b1;
        @(posedge clk);
        smp <= 1'b0;
        @(posedge clk);
    endtask : note_out

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(21587));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        l_pad_in <= 2'($urandom);
        @(posedge clk);
        note_out(1, RST_OE_N, 8'hFF);
        foreach (alist[i]) rd_reg(alist[i], 8'h00, chk(alist[i]));
        foreach (alist[i]) begin
            regv[alist[i]] = 8'($urandom);
            wr_reg(alist[i], regv[alist[i]]);
        end
        foreach (alist[i]) rd_reg(alist[i], regv[alist[i]] & msk(alist[i]), chk(alist[i]));
        rd_reg(ADDR_L_LEVEL, {6'h00, l_pad_in}, 8'hFF);
        note_out(6, regv[8'h06], 8'hFF);
        note_out(7, regv[8'h07], 8'hFF);
        note_out(8, regv[8'h04], 8'hFF);
        note_out(9, regv[8'h05], 8'hFF);
        note_out(10, {regv[8'h13][1:0], l_pad_in, regv[8'h11][1:0], regv[8'h12][1:0]}, 8'hFF);
        wr_reg(ADDR_A_DIG_GATE, 8'hFF);
        wr_reg(ADDR_A_PULL_EN, 8'hFF);
        wr_reg(ADDR_A_POLARITY, 8'h00);
        wr_reg(ADDR_A_OPEN_DRAIN, 8'h00);
        wr_reg(ADDR_A_LATCH, 8'hA5);
        wr_reg(ADDR_A_DIR, 8'hFF);
        settle();
        note_out(1, 8'h00, 8'hFF);
        note_out(2, 8'hA5, 8'hFF);
        note_out(3, 8'h00, 8'hFF);
        rd_reg(ADDR_A_LATCH, 8'hA5, 8'hFF);
        wr_reg(ADDR_A_POLARITY, 8'hFF);
        wr_reg(ADDR_A_OPEN_DRAIN, 8'hFF);
        settle();
        note_out(4, 8'h00, 8'hFF);
        wr_reg(ADDR_A_OPEN_DRAIN, 8'h00);
        wr_reg(ADDR_A_POLARITY, 8'h3F);
        wr_reg(ADDR_A_DIR, 8'h40);
        wr_reg(ADDR_A_LATCH, 8'h40);
        ocmp_en <= 8'h01;
        ocmp_out <= 8'h01;
        spi_en <= 8'h22;
        spi_oe <= 8'h02;
        spi_out <= 8'h02;
        sent_en <= 8'h04;
        dac_en <= 8'h08;
        iic_en <= 8'h10;
        in_only <= 8'h40;
        ext_en <= 8'hFF;
        settle();
        note_out(1, 8'hE8, 8'hFF);
        note_out(2, 8'h03, 8'h17);
        note_out(3, 8'hC0, 8'hFF);
        note_out(4, 8'h20, 8'hFF);
        repeat (3) begin
            r = 8'($urandom);
            ext_val <= r;
            settle();
            wr_reg(ADDR_A_LEVEL, 8'hFF);
            rd_reg(ADDR_A_LEVEL, {r[7:5], 1'b0, r[3], 3'b011}, 8'hFF);
            rd_reg(ADDR_A_LATCH, {r[7], 1'b1, r[5], 1'b0, r[3], 3'b011}, 8'hFF);
            note_out(5, {r[7:5], 1'b0, r[3], 3'b011}, 8'hFF);
        end
        dac_en <= 8'h09;
        spi_en <= 8'h26;
        spi_oe <= 8'h06;
        spi_out <= 8'h06;
        settle();
        note_out(1, 8'hE9, 8'hFF);
        note_out(2, 8'h06, 8'h16);
        note_out(4, 8'h20, 8'hFF);
        wr_reg(ADDR_A_DIR, 8'hB7);
        rd_reg(ADDR_A_DIR, 8'hB7, 8'hFF);
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule : ppc_port_pin_io_control_bench
